// ===== hdl/mapper_defs.svh
// Address map constants and timing counts for the program/data space mapper
// What this block does
// - Program counter steps by two per 24-bit program word.
// - Table page top bit selects user or configuration space.
// - Low table read returns program bits 15:0 unchanged.
// - Low byte read gives bits 7:0 or 15:8 by byte select.
// - High table read puts bits 23:16 low, upper byte zero.
// - High byte read gives bits 23:16 or zero by byte select.
// - Window used only when address MSB set and enable bit set.
// - Upper 32 Kbyte data half maps onto any 16K-word program page.
// - Low 15 address bits pass, window page supplies upper bits.
// - Window page is 8 bits, program address bits 22:15.
// - Window reads return only the low 16 program bits.
// - Window mapping suspended during table reads or writes.
// - Outside repeat: one extra cycle dual/move, two for others.
// - In repeat: two extra on first, last, interrupt exit, re-entry; else none.
// - Non dual-operand instructions see full 64 Kbyte space as X.
// - Dual reads: Y only via Y pointers, X only via X pointers.
// - Only dual-operand instructions read X and Y concurrently.
// - All data writes use the X write bus, never the Y bus; table writes use the program bus.
// - Accumulator write back uses X bus to any data address.
// - Bit-reversed addressing only for X writes; modulo in X and Y. Neither is applied here; bit_rev is unused.
// - X/Y boundary fixed in hardware, not software changeable.
// - Reads outside assigned space or physical memory return zero.
// - Unimplemented address access also raises an address error trap.
`ifndef MAPPER_DEFS_SVH
`define MAPPER_DEFS_SVH
`define PC_STEP          23'h000002
`define Y_BASE_DEF       16'h0800
`define Y_LIMIT_DEF      16'h17ff
`define RAM_LIMIT_DEF    16'h17ff
`define SFR_LIMIT_DEF    16'h07ff
`define WIN_BIT          15
`define REG_CTRL         8'h00
`define REG_WIN_PAGE     8'h04
`define REG_TBL_PAGE     8'h08
`define REG_STATUS       8'h0c
`define CTRL_WIN_EN_BIT  0
`define WIN_PAGE_RST     8'h00
`define TBL_PAGE_RST     8'h00
`define CTRL_RST         1'b0
`define EXTRA_SHORT      2'd1
`define EXTRA_LONG       2'd2
`endif

// ===== hdl/mapper_pkg.sv
// Types shared by the program/data space mapper
package mapper_pkg;
  typedef enum logic [3:0] {
    op_none       = 4'b0001,
    op_table_read = 4'b0010,
    op_table_write= 4'b0100,
    op_data       = 4'b1000
  } op_kind_t;
  typedef struct packed {
    logic        valid;
    op_kind_t    kind;
    logic        high;       // table high half
    logic        byte_mode;
    logic        write;
    logic        dual_class; // dual-operand instruction
    logic        move_class; // move instructions with single extra cycle
    logic        in_repeat;
    logic        rep_edge;   // first/last/interrupt exit/re-entry iteration
    logic        bit_rev;
    logic        use_y_ptr;  // address came from a Y pointer
    logic        use_x_ptr;  // address came from an X pointer
    logic [15:0] ea;
    logic [15:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [1:0]  extra;
    logic        addr_trap;
  } mem_rsp_t;
endpackage : mapper_pkg

// ===== hdl/program_data_space_mapper.sv
// Program and data space address generation and routing
`timescale 1ns/1ps
`include "mapper_defs.svh"
module program_data_space_mapper
  import mapper_pkg::*;
#(
  parameter logic [15:0] Y_BASE    = `Y_BASE_DEF,
  parameter logic [15:0] Y_LIMIT   = `Y_LIMIT_DEF,
  parameter logic [15:0] RAM_LIMIT = `RAM_LIMIT_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pipeline side
  input  wire logic        pc_advance,
  input  wire logic        pc_load,
  input  wire logic [22:0] pc_target,
  input  wire mem_req_t    req,
  output mem_rsp_t         rsp,
  output logic      [23:0] fetch_addr,
  // Memory side
  output logic      [23:0] prog_addr,
  output logic             prog_rd,
  output logic             prog_wr,
  output logic      [15:0] prog_wdata,
  input  wire logic [23:0] prog_rdata,
  output logic      [15:0] x_addr,
  output logic             x_rd,
  output logic             x_wr,
  output logic      [15:0] x_wdata,
  input  wire logic [15:0] x_rdata,
  output logic      [15:0] y_addr,
  output logic             y_rd,
  input  wire logic [15:0] y_rdata
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= Y_BASE) && (a <= Y_LIMIT);
  endfunction : in_y

  function automatic logic implemented(input logic [15:0] a);
    implemented = (a <= RAM_LIMIT);
  endfunction : implemented

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic        win_enable;
  logic [7:0]  program_window_page;
  logic [7:0]  table_page_reg;
  logic        trap_seen;
  logic        ph_valid;
  logic        ph_write;
  logic [31:0] ph_addr;
  logic [22:0] pc;

  wire bus_take = hsel && hready && htrans[1];

  // Address phase capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 32'h0;
    end else if (hready) begin
      ph_valid <= bus_take;
      ph_write <= hwrite;
      ph_addr  <= haddr;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      win_enable          <= `CTRL_RST;
      program_window_page <= `WIN_PAGE_RST;
      table_page_reg      <= `TBL_PAGE_RST;
    end else if (ph_valid && ph_write) begin
      unique case (ph_addr[7:0])
        `REG_CTRL:     win_enable          <= hwdata[`CTRL_WIN_EN_BIT];
        `REG_WIN_PAGE: program_window_page <= hwdata[7:0];
        `REG_TBL_PAGE: table_page_reg      <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data and always-ready OKAY response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (bus_take && !hwrite) begin
        unique case (haddr[7:0])
          `REG_CTRL:     hrdata <= {31'h0, win_enable};
          `REG_WIN_PAGE: hrdata <= {24'h0, program_window_page};
          `REG_TBL_PAGE: hrdata <= {24'h0, table_page_reg};
          `REG_STATUS:   hrdata <= {8'h0, pc, trap_seen};
          default:       hrdata <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Program counter and fetch address
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc <= 23'h0;
    end else if (pc_load) begin
      pc <= {pc_target[22:1], 1'b0};
    end else if (pc_advance) begin
      pc <= pc + `PC_STEP;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fetch_addr <= 24'h0;
    end else begin
      fetch_addr <= {1'b0, pc[22:1], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Request decode (combinational)
  // ------------------------------------------------------------
  logic is_table;
  logic use_window;
  logic dual_read;
  logic x_bad;
  logic y_bad;
  logic unimpl;
  logic [1:0] extra_c;

  always_comb begin
    is_table   = req.valid &&
                 (req.kind == op_table_read || req.kind == op_table_write);
    use_window = req.valid && req.kind == op_data && !req.write &&
                 req.ea[`WIN_BIT] && win_enable;
    dual_read  = req.valid && req.kind == op_data && req.dual_class &&
                 !req.write;
    // wrong pointer for the region returns zero
    x_bad  = dual_read && req.use_x_ptr && in_y(req.ea);
    y_bad  = dual_read && req.use_y_ptr && !in_y(req.ea);
    unimpl = req.valid && req.kind == op_data && !use_window &&
             !implemented(req.ea);
    extra_c = 2'd0;
    if (use_window) begin
      if (req.in_repeat) begin
        extra_c = req.rep_edge ? `EXTRA_LONG : 2'd0;
      end else if (req.dual_class || req.move_class) begin
        extra_c = `EXTRA_SHORT;
      end else begin
        extra_c = `EXTRA_LONG;
      end
    end
  end

  // ------------------------------------------------------------
  // Memory strobes and addresses
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_addr  <= 24'h0;
      prog_rd    <= 1'b0;
      prog_wr    <= 1'b0;
      prog_wdata <= 16'h0;
    end else begin
      prog_rd <= (is_table && req.kind == op_table_read) || use_window;
      prog_wr <= is_table && req.kind == op_table_write;
      prog_wdata <= req.wdata;
      if (is_table) begin
        prog_addr <= {table_page_reg, req.ea};
      end else begin
        prog_addr <= {1'b0, program_window_page, req.ea[14:0]};
      end
    end
  end

  // X bus carries all data writes, including accumulator write back; table writes use the program bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      x_addr  <= 16'h0;
      x_rd    <= 1'b0;
      x_wr    <= 1'b0;
      x_wdata <= 16'h0;
      y_addr  <= 16'h0;
      y_rd    <= 1'b0;
    end else begin
      x_addr  <= req.ea;
      x_rd    <= req.valid && req.kind == op_data && !req.write &&
                 !use_window && !x_bad && !y_bad && !req.use_y_ptr &&
                 implemented(req.ea);
      x_wr    <= req.valid && req.kind == op_data && req.write &&
                 implemented(req.ea);
      x_wdata <= req.wdata;
      y_addr  <= req.ea;
      y_rd    <= dual_read && req.use_y_ptr && !y_bad;
    end
  end

  // ------------------------------------------------------------
  // Response pipeline: one cycle behind the strobes
  // ------------------------------------------------------------
  logic       p_valid;
  logic       p_table;
  logic       p_high;
  logic       p_byte;
  logic       p_sel;
  logic       p_win;
  logic       p_zero;
  logic       p_y;
  logic [1:0] p_extra;
  logic       p_trap;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p_valid <= 1'b0;
      p_table <= 1'b0;
      p_high  <= 1'b0;
      p_byte  <= 1'b0;
      p_sel   <= 1'b0;
      p_win   <= 1'b0;
      p_zero  <= 1'b0;
      p_y     <= 1'b0;
      p_extra <= 2'd0;
      p_trap  <= 1'b0;
    end else begin
      // Only reads answer; table writes and data writes give no response
      p_valid <= req.valid && !req.write && req.kind != op_table_write;
      p_table <= is_table;
      p_high  <= req.high;
      p_byte  <= req.byte_mode;
      p_sel   <= req.ea[0];
      p_win   <= use_window;
      p_zero  <= x_bad || y_bad || unimpl;
      p_y     <= dual_read && req.use_y_ptr;
      p_extra <= extra_c;
      p_trap  <= unimpl;
    end
  end

  logic [15:0] next_data;

  always_comb begin
    next_data = 16'h0;
    if (p_zero) begin
      next_data = 16'h0;
    end else if (p_table) begin
      unique case ({p_high, p_byte})
        2'b00: next_data = prog_rdata[15:0];
        2'b01: next_data = {8'h0, p_sel ? prog_rdata[15:8] : prog_rdata[7:0]};
        2'b10: next_data = {8'h0, prog_rdata[23:16]};
        2'b11: next_data = {8'h0, p_sel ? 8'h00 : prog_rdata[23:16]};
      endcase
    end else if (p_win) begin
      next_data = prog_rdata[15:0];
    end else if (p_y) begin
      next_data = y_rdata;
    end else begin
      next_data = x_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp       <= '0;
      trap_seen <= 1'b0;
    end else begin
      rsp.valid     <= p_valid;
      rsp.data      <= next_data;
      rsp.extra     <= p_extra;
      rsp.addr_trap <= p_trap;
      if (p_trap) begin
        trap_seen <= 1'b1;
      end else if (ph_valid && ph_write && ph_addr[7:0] == `REG_STATUS) begin
        trap_seen <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  pc_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    pc_advance && !pc_load |=> pc == $past(pc) + `PC_STEP)
    else $error("pc step wrong");
  fetch_form_a: assert property (@(posedge clk_sys) disable iff (rst)
    fetch_addr[23] == 1'b0 && fetch_addr[0] == 1'b0)
    else $error("fetch address form");
  table_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
    is_table |=> prog_addr == {$past(table_page_reg), $past(req.ea)})
    else $error("table address");
  window_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
    use_window |=> prog_addr[22:15] == $past(program_window_page) && prog_rd)
    else $error("window address");
  window_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid && req.kind == op_data && !(req.ea[15] && win_enable)
    |=> !prog_rd)
    else $error("window without enable");
  no_y_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid && req.write |=> !y_rd)
    else $error("write with y read");
  zero_data_a: assert property (@(posedge clk_sys) disable iff (rst)
    (x_bad || y_bad) |-> ##2 rsp.data == 16'h0)
    else $error("bad space not zero");
  extra_a: assert property (@(posedge clk_sys) disable iff (rst)
    use_window && !req.in_repeat && !req.dual_class && !req.move_class
    |-> ##2 rsp.extra == `EXTRA_LONG)
    else $error("extra cycles wrong");
  trap_a: assert property (@(posedge clk_sys) disable iff (rst)
    unimpl |-> ##2 rsp.addr_trap && trap_seen)
    else $error("trap missing");
  window_cov: cover property (@(posedge clk_sys) disable iff (rst) use_window);
  table_cov: cover property (@(posedge clk_sys) disable iff (rst) is_table);
  dual_cov: cover property (@(posedge clk_sys) disable iff (rst) dual_read && y_rd);

endmodule : program_data_space_mapper

// ===== test/mapper_mem_model.sv
// Program memory and data RAM model facing the mapper
`timescale 1ns/1ps
module mapper_mem_model (
  input  wire logic [23:0] prog_addr,
  input  wire logic        prog_rd,
  output logic      [23:0] prog_rdata,
  input  wire logic [15:0] x_addr,
  input  wire logic        x_rd,
  output logic      [15:0] x_rdata,
  input  wire logic [15:0] y_addr,
  input  wire logic        y_rd,
  output logic      [15:0] y_rdata
);
  // Contents derive from the address; an unselected bus shows the inverse
  wire logic [23:0] pw = {prog_addr[23:16] ^ 8'h96, prog_addr[15:0] ^ 16'h3c5a};
  wire logic [15:0] xw = x_addr ^ 16'h1234;
  wire logic [15:0] yw = y_addr ^ 16'h4321;
  assign prog_rdata = prog_rd ? pw : ~pw;
  assign x_rdata = x_rd ? xw : ~xw;
  assign y_rdata = y_rd ? yw : ~yw;
endmodule : mapper_mem_model

// ===== test/program_data_space_mapper_tb.sv
// Self-checking bench for the program/data space mapper
`timescale 1ns/1ps
module program_data_space_mapper_tb;
  import mapper_pkg::*;
  localparam logic [9:0] F_HI = 10'h200, F_BY = 10'h100, F_WR = 10'h080, F_DU = 10'h040;
  localparam logic [9:0] F_MV = 10'h020, F_RP = 10'h010, F_ED = 10'h008;
  localparam logic [9:0] F_UY = 10'h002, F_UX = 10'h001;
  logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        pc_advance = 1'b0, pc_load = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [22:0] pc_target = 23'h0;
  mem_req_t    req = '0;
  mem_rsp_t    rsp, s_rsp;
  logic [23:0] fetch_addr, prog_addr, prog_rdata, s_pa;
  logic        prog_rd, prog_wr, x_rd, x_wr, y_rd;
  logic [15:0] prog_wdata, x_addr, x_wdata, x_rdata, y_addr, y_rdata, s_xa, s_ya, s_xw;
  logic [3:0]  s_st;
  logic [16:0] s_pw;
  int          n_fail = 0, cmp_count = 0;

  // ----------------------------------------
  // Clock, design and memory model
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;
  program_data_space_mapper dut (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hready     (hreadyout),
    .hwdata     (hwdata),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .pc_advance (pc_advance),
    .pc_load    (pc_load),
    .pc_target  (pc_target),
    .req        (req),
    .rsp        (rsp),
    .fetch_addr (fetch_addr),
    .prog_addr  (prog_addr),
    .prog_rd    (prog_rd),
    .prog_wr    (prog_wr),
    .prog_wdata (prog_wdata),
    .prog_rdata (prog_rdata),
    .x_addr     (x_addr),
    .x_rd       (x_rd),
    .x_wr       (x_wr),
    .x_wdata    (x_wdata),
    .x_rdata    (x_rdata),
    .y_addr     (y_addr),
    .y_rd       (y_rd),
    .y_rdata    (y_rdata)
  );
  mapper_mem_model mem (
    .prog_addr  (prog_addr),
    .prog_rd    (prog_rd),
    .prog_rdata (prog_rdata),
    .x_addr     (x_addr),
    .x_rd       (x_rd),
    .x_rdata    (x_rdata),
    .y_addr     (y_addr),
    .y_rd       (y_rd),
    .y_rdata    (y_rdata)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[23:16] ^ 8'h96, a[15:0] ^ 16'h3c5a};
  endfunction : pw

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task conclude;
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Single word transfer; address phase held until hready seen high
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  // One pipeline request; strobes captured at +1, response at +2
  task go(input op_kind_t k, input logic [15:0] ea, input logic [9:0] f);
    @(posedge clk_sys);
    req <= {1'b1, k, f, ea, 16'h5a5a};
    @(posedge clk_sys);
    req <= '0;
    #1;
    s_pa = prog_addr;
    s_st = {prog_rd, x_rd, y_rd, x_wr};
    s_xa = x_addr;
    s_ya = y_addr;
    s_xw = x_wdata;
    s_pw = {prog_wr, prog_wdata};
    @(posedge clk_sys);
    #1;
    s_rsp = rsp;
  endtask : go

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    logic [31:0] q;
    ahb(1'b0, 32'h0, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b0, 32'h4, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b1, 32'h40, 32'hffffffff, q);
    ahb(1'b0, 32'h40, 32'h0, q);
    chk(q, 32'h0);
    chk({hreadyout, hresp}, 32'h2);
    ahb(1'b1, 32'h4, 32'hffffffa7, q);
    ahb(1'b0, 32'h4, 32'h0, q);
    chk(q, 32'ha7);
  endtask : t_regs

  task t_fetch;
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_target <= 23'h7ffff3;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    pc_advance <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(fetch_addr, 24'h7ffff2);
    repeat (2) @(posedge clk_sys);
    pc_advance <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(fetch_addr, 24'h7ffff8);
  endtask : t_fetch

  task t_table;
    logic [31:0] q;
    logic [7:0]  pg;
    logic [15:0] ea, e, m;
    logic [23:0] w;
    for (int j = 0; j < 2; j++) begin
      pg = j ? 8'h05 : 8'h81;
      ahb(1'b1, 32'h8, {24'h0, pg}, q);
      for (int i = 0; i < 8; i++) begin
        ea = 16'h4a30 | 16'(i[0]);
        go(op_table_read, ea, (i[2] ? F_HI : 10'h0) | (i[1] ? F_BY : 10'h0));
        w = pw({pg, ea});
        m = i[1] ? 16'h00ff : 16'hffff;
        if (i[2]) e = {8'h00, (i[1] && i[0]) ? 8'h00 : w[23:16]};
        else e = i[1] ? {8'h00, i[0] ? w[15:8] : w[7:0]} : w[15:0];
        chk(s_pa, {pg, ea});
        chk(s_rsp.valid, 1'b1);
        chk(s_rsp.data & m, e);
      end
    end
    go(op_table_write, 16'h1230, 10'h0);
    chk(s_pa, {pg, 16'h1230});
    chk(s_pw, 17'h15a5a);
    chk(s_rsp.valid, 1'b0);
  endtask : t_table

  task t_window;
    logic [31:0] q;
    logic [23:0] w;
    logic [9:0]  wf [5] = '{10'h0, F_MV, F_DU | F_UX, F_RP, F_RP | F_ED};
    logic [1:0]  we [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h2};
    ahb(1'b1, 32'h4, 32'ha7, q);
    ahb(1'b1, 32'h0, 32'h1, q);
    w = pw({1'b0, 8'ha7, 15'h1abc});
    for (int i = 0; i < 5; i++) begin
      go(op_data, 16'h9abc, wf[i]);
      chk(s_pa, {1'b0, 8'ha7, 15'h1abc});
      chk(s_rsp.data, w[15:0]);
      chk(s_rsp.extra, we[i]);
    end
    go(op_table_read, 16'h9abc, 10'h0);
    chk(s_pa, 24'h059abc);
    ahb(1'b1, 32'h0, 32'h0, q);
    go(op_data, 16'h9abc, 10'h0);
    chk(s_st[3], 1'b0);
    chk(s_rsp.data, 32'h0);
    chk(s_rsp.addr_trap, 1'b1);
    ahb(1'b0, 32'hc, 32'h0, q);
    chk(q, 32'h00fffff1);
    ahb(1'b1, 32'hc, 32'h0, q);
    ahb(1'b0, 32'hc, 32'h0, q);
    chk(q, 32'h00fffff0);
  endtask : t_window

  task t_xy;
    go(op_data, 16'h0900, 10'h0);
    chk(s_st, 4'h4);
    chk(s_xa, 16'h0900);
    chk(s_rsp.data, 16'h1b34);
    go(op_data, 16'h0900, F_DU | F_UX);
    chk(s_rsp.data, 16'h0);
    go(op_data, 16'h0800, F_DU | F_UY);
    chk(s_st[1], 1'b1);
    chk(s_ya, 16'h0800);
    chk(s_rsp.data, 16'h4b21);
    go(op_data, 16'h07fe, F_DU | F_UY);
    chk(s_rsp.data, 16'h0);
    go(op_data, 16'h0900, F_WR | F_DU);
    chk(s_st, 4'h1);
    chk({s_xa, s_xw}, 32'h09005a5a);
    go(op_data, 16'h0200, F_WR | 10'h004);
    chk(s_st, 4'h1);
  endtask : t_xy

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_fetch;
    t_table;
    t_window;
    t_xy;
    conclude;
  end

  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    conclude;
  end
endmodule : program_data_space_mapper_tb
